// >>> verilog/ldhwp_pkg.sv
// Package: control word layout and shared types for the host write port
package ldhwp_pkg;
    localparam int CTL_ADDR_LSB = 0;
    localparam int CTL_ADDR_MSB = 2;
    localparam int CTL_BANK_BIT = 3;
    localparam int CTL_POWER_BIT = 4;
    localparam int CTL_NODEC_BIT = 5;
    localparam int CTL_HEX_BIT = 6;
    localparam int CTL_SEQ_BIT = 7;
    localparam logic [7:0] CTL_RESET = 8'h10;
    localparam int SEQ_DIGITS = 8;
    localparam int FIFO_DEPTH = 16;

    typedef struct packed {
        logic seq_flag;
        logic hex_sel;
        logic nodecode_sel;
        logic power_on;
        logic bank_a;
        logic [2:0] digit_addr;
    } ldhwp_ctl_t;

    typedef struct packed {
        logic [2:0] digit;
        logic [7:0] data;
    } ldhwp_wr_t;
endpackage : ldhwp_pkg

// >>> verilog/ldhwp_fifo.sv
// Parameterised valid/ready FIFO
`timescale 1ns/1ns
module ldhwp_fifo #(
    parameter int WIDTH = 11,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem_q[rd_q];

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= rd_q + AW'(1);
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : ldhwp_fifo

// >>> verilog/ldhwp_top.sv
// Host write port and control-word decoding of an 8-digit LED driver
// Overview of operation
// - Capture bus on write strobe rising edge
// - Select high loads control, low loads RAM
// - RAM byte lines 0-7; bit 7 decimal point
// - Line six selects hex or Code B
// - Line five high selects no-decode
// - Line seven high announces sequential data
// - Line four low enters shutdown
// - Lines 0-2 give single-digit address
// - Line three selects bank, decode modes only
`timescale 1ns/1ns
module ldhwp_top (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // Host pins
    input wire logic [7:0] in_data_bus,
    input wire logic mode_sel,
    input wire logic write_strobe,
    // Display memory port (held when read side stalls)
    input wire logic ram_wr_ready,
    output logic ram_wr_valid,
    output logic [2:0] ram_wr_digit,
    output logic [7:0] ram_wr_data,
    output logic ram_wr_dp,
    // Decoded control state
    output logic decode_scheme_select,
    output logic nodecode_active,
    output logic shutdown_active,
    output logic bank_a_select,
    output logic seq_active,
    output logic [7:0] ctl_word_view
);
    typedef enum logic [1:0] {ST_IDLE, ST_SEQ, ST_SINGLE} ldhwp_state_t;

    logic [7:0] data_s1_q;
    logic [7:0] data_s2_q;
    logic mode_s1_q;
    logic mode_s2_q;
    logic wr_s1_q;
    logic wr_s2_q;
    logic wr_s3_q;
    logic wr_edge;
    ldhwp_pkg::ldhwp_ctl_t ctl_q;
    ldhwp_state_t state_q;
    logic [2:0] seq_cnt_q;
    logic fifo_in_ready;
    logic ram_push;
    logic [2:0] push_digit;
    ldhwp_pkg::ldhwp_wr_t push_word;
    ldhwp_pkg::ldhwp_wr_t pop_word;

    // Pin synchronisers
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            data_s1_q <= 8'h00;
            data_s2_q <= 8'h00;
            mode_s1_q <= 1'b0;
            mode_s2_q <= 1'b0;
            wr_s1_q <= 1'b0;
            wr_s2_q <= 1'b0;
            wr_s3_q <= 1'b0;
        end else begin
            data_s1_q <= in_data_bus;
            data_s2_q <= data_s1_q;
            mode_s1_q <= mode_sel;
            mode_s2_q <= mode_s1_q;
            wr_s1_q <= write_strobe;
            wr_s2_q <= wr_s1_q;
            wr_s3_q <= wr_s2_q;
        end
    end

    assign wr_edge = wr_s2_q && !wr_s3_q;

    // Control word
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            ctl_q <= ldhwp_pkg::CTL_RESET;
        end else if (wr_edge && mode_s2_q) begin
            ctl_q.seq_flag <= data_s2_q[ldhwp_pkg::CTL_SEQ_BIT];
            ctl_q.hex_sel <= data_s2_q[ldhwp_pkg::CTL_HEX_BIT];
            ctl_q.nodecode_sel <= data_s2_q[ldhwp_pkg::CTL_NODEC_BIT];
            ctl_q.power_on <= data_s2_q[ldhwp_pkg::CTL_POWER_BIT];
            ctl_q.bank_a <= data_s2_q[ldhwp_pkg::CTL_BANK_BIT];
            if (!data_s2_q[ldhwp_pkg::CTL_SEQ_BIT]) begin
                ctl_q.digit_addr <= data_s2_q[ldhwp_pkg::CTL_ADDR_MSB:
                    ldhwp_pkg::CTL_ADDR_LSB];
            end
        end
    end

    // Write sequencing
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            seq_cnt_q <= 3'h0;
        end else if (wr_edge && mode_s2_q) begin
            seq_cnt_q <= 3'h0;
            state_q <= data_s2_q[ldhwp_pkg::CTL_SEQ_BIT] ? ST_SEQ
                : ST_SINGLE;
        end else if (ram_push) begin
            unique case (state_q)
                ST_SEQ: begin
                    seq_cnt_q <= seq_cnt_q + 3'h1;
                    if (seq_cnt_q == 3'(ldhwp_pkg::SEQ_DIGITS - 1)) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_SINGLE: begin
                    state_q <= ST_IDLE;
                end
                ST_IDLE: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign push_digit = (state_q == ST_SEQ) ? seq_cnt_q
        : ctl_q.digit_addr;
    assign ram_push = wr_edge && !mode_s2_q && (state_q != ST_IDLE)
        && fifo_in_ready;
    assign push_word.digit = push_digit;
    assign push_word.data = data_s2_q;

    ldhwp_fifo #(
        .WIDTH($bits(ldhwp_pkg::ldhwp_wr_t)),
        .DEPTH(ldhwp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .in_valid(ram_push),
        .in_ready(fifo_in_ready),
        .in_data(push_word),
        .out_valid(ram_wr_valid),
        .out_ready(ram_wr_ready),
        .out_data(pop_word)
    );

    assign ram_wr_digit = pop_word.digit;
    assign ram_wr_data = pop_word.data;
    assign ram_wr_dp = pop_word.data[7];

    assign decode_scheme_select = ctl_q.hex_sel;
    assign nodecode_active = ctl_q.nodecode_sel;
    assign shutdown_active = !ctl_q.power_on;
    assign bank_a_select = ctl_q.bank_a && !ctl_q.nodecode_sel;
    assign seq_active = (state_q == ST_SEQ);
    assign ctl_word_view = ctl_q;

    ctl_load_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        wr_edge && mode_s2_q |=> ctl_word_view[4] == $past(data_s2_q[4]))
        else $error("power bit not loaded");
    hex_load_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        wr_edge && mode_s2_q |=> decode_scheme_select == $past(data_s2_q[6]))
        else $error("decode scheme not loaded");
    nodec_load_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        wr_edge && mode_s2_q |=> nodecode_active == $past(data_s2_q[5]))
        else $error("no-decode bit not loaded");
    seq_enter_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        wr_edge && mode_s2_q && data_s2_q[7] |=> seq_active)
        else $error("sequential mode not entered");
    addr_load_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        wr_edge && mode_s2_q && !data_s2_q[7]
        |=> ctl_word_view[2:0] == $past(data_s2_q[2:0]))
        else $error("digit address not loaded");
    bank_gate_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        wr_edge && mode_s2_q
        |=> bank_a_select == $past(data_s2_q[3] && !data_s2_q[5]))
        else $error("bank select not gated by decode mode");
    ram_sel_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        ram_push |-> wr_edge && !mode_s2_q)
        else $error("RAM push without low select");
    single_done_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        ram_push && state_q == ST_SINGLE |=> state_q == ST_IDLE)
        else $error("single write not closed");
    seq_end_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        ram_push && seq_active && seq_cnt_q == 3'h7 |=> !seq_active)
        else $error("sequence not ended after eight");
    edge_src_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        wr_edge |-> $past(write_strobe, 2))
        else $error("edge without rising strobe");
    data_path_a: assert property (@(posedge clk_sys)
        disable iff (sys_rst)
        ram_push && !ram_wr_valid |=> ram_wr_valid
        && ram_wr_data == $past(data_s2_q)
        && ram_wr_digit == $past(push_digit))
        else $error("RAM byte not from bus");

    seq_cov_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        seq_active ##1 !seq_active);
    single_cov_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        ram_push && state_q == ST_SINGLE);
    full_cov_c: cover property (@(posedge clk_sys) disable iff (sys_rst)
        !fifo_in_ready);
endmodule : ldhwp_top

// >>> tb/ldhwp_host_model.sv
// Host microprocessor model driving the write port pins
`timescale 1ns/1ns
module ldhwp_host_model (
    // Clock
    input wire logic clk_sys,
    // Host pins
    output logic [7:0] in_data_bus,
    output logic mode_sel,
    output logic write_strobe
);
    initial begin
        in_data_bus = 8'h00;
        mode_sel = 1'b0;
        write_strobe = 1'b0;
    end

    // Three clocks of setup before the strobe rise and three of hold after its fall
    task automatic host_write(input logic mode, input logic [7:0] data);
        in_data_bus = data;
        mode_sel = mode;
        repeat (3) @(negedge clk_sys);
        write_strobe = 1'b1;
        repeat (3) @(negedge clk_sys);
        write_strobe = 1'b0;
        repeat (3) @(negedge clk_sys);
        in_data_bus = ~data;
        mode_sel = ~mode;
        @(negedge clk_sys);
    endtask : host_write
endmodule : ldhwp_host_model

// >>> tb/test_led_driver_host_write_port.sv
// Self-checking bench for the LED driver host write port
`timescale 1ns/1ns
module test_led_driver_host_write_port;
    logic clk_sys, sys_rst, ram_wr_ready, mode_sel, write_strobe;
    logic ram_wr_valid, ram_wr_dp, dss, nodec, sdown, bank_a, seq_act;
    logic [2:0] ram_wr_digit;
    logic [7:0] in_data_bus, ram_wr_data, ctl_view;
    logic [15:0] e;
    logic [10:0] exp_q[$];
    logic [7:0] ctl_tab[4] = '{8'h58, 8'h3B, 8'h05, 8'h4E};
    int miscompares = 0;
    int tests_run = 0;

    ldhwp_top uut (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .in_data_bus(in_data_bus), .mode_sel(mode_sel),
        .write_strobe(write_strobe), .ram_wr_ready(ram_wr_ready),
        .ram_wr_valid(ram_wr_valid), .ram_wr_digit(ram_wr_digit),
        .ram_wr_data(ram_wr_data), .ram_wr_dp(ram_wr_dp),
        .decode_scheme_select(dss), .nodecode_active(nodec),
        .shutdown_active(sdown), .bank_a_select(bank_a),
        .seq_active(seq_act), .ctl_word_view(ctl_view));

    ldhwp_host_model host (.clk_sys(clk_sys), .in_data_bus(in_data_bus),
        .mode_sel(mode_sel), .write_strobe(write_strobe));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    task automatic ram_write(input logic [2:0] dig, input logic [7:0] d);
        host.host_write(1'b0, d);
        exp_q.push_back({dig, d});
    endtask : ram_write

    // Pops one queued word per cycle, display queue stalled until now
    task automatic drain;
        logic [10:0] w;
        while (exp_q.size() > 0) begin
            w = exp_q.pop_front();
            check({4'h0, ram_wr_valid, ram_wr_digit, ram_wr_data},
                  {4'h0, 1'b1, w});
            check({15'h0000, ram_wr_dp}, {15'h0000, w[7]});
            ram_wr_ready = 1'b1;
            @(negedge clk_sys);
        end
        ram_wr_ready = 1'b0;
        check({15'h0000, ram_wr_valid}, 16'h0000);
    endtask : drain

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    initial begin
        sys_rst = 1'b1;
        ram_wr_ready = 1'b0;
        repeat (4) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk_sys);
        check({8'h00, ctl_view}, 16'h0010);
        // Display write with no control word is dropped
        host.host_write(1'b0, 8'h5A);
        check({15'h0000, ram_wr_valid}, 16'h0000);
        foreach (ctl_tab[i]) begin
            host.host_write(1'b1, ctl_tab[i]);
            e = {ctl_tab[i], 3'h0, ctl_tab[i][6], ctl_tab[i][5],
                 ~ctl_tab[i][4], ctl_tab[i][3] & ~ctl_tab[i][5], 1'b0};
            check({ctl_view, 3'h0, dss, nodec, sdown, bank_a, seq_act},
                  e);
        end
        // Two bursts fill the 16-word queue while it stalls
        repeat (2) begin
            host.host_write(1'b1, 8'hD0);
            check({15'h0000, seq_act}, 16'h0001);
            for (int k = 0; k < 8; k++) begin
                ram_write(k[2:0], 8'h93 ^ (k[7:0] * 8'h25));
            end
        end
        check({15'h0000, seq_act}, 16'h0000);
        host.host_write(1'b1, 8'h15);
        host.host_write(1'b0, 8'hEE);
        drain();
        ram_write(3'h5, 8'h7C);
        drain();
        host.host_write(1'b0, 8'h33);
        check({15'h0000, ram_wr_valid}, 16'h0000);
        conclude();
    end
endmodule : test_led_driver_host_write_port
